// ===== hw/hpci_pkg.sv
/*
  constants shared by both ends of the parallel host port: register offsets, field
  positions, reset values and strobe timing.
  assumes a 100 MHz clk_sys on both ends.
*/
package hpci_pkg;
  // ==========================================================================
  // device-side register map (word addresses on the software port)
  localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
  localparam logic [3:0]  ADDR_INT_ENABLE = 4'h1;
  localparam logic [3:0]  ADDR_INT_STATUS = 4'h2;
  localparam logic [3:0]  ADDR_IN_DATA    = 4'h3;
  localparam logic [3:0]  ADDR_OUT_DATA   = 4'h4;

  // host_port_control fields
  localparam int          CTL_WIDTH_SEL   = 0;
  localparam int          CTL_PROTO_SEL   = 1;
  localparam int          CTL_STRB_POL    = 2;
  localparam int          CTL_BSEL_SENSE  = 3;
  localparam int          CTL_FLAG_POL    = 4;
  localparam int          CTL_MERGE_SEL   = 5;
  localparam int          CTL_STAT_POL    = 6;
  localparam int          CTL_BITS        = 7;
  localparam logic [6:0]  CTL_RESET       = 7'h00;

  // interrupt_enable / interrupt_status fields
  localparam int          INT_OBE_BIT     = 2;
  localparam int          INT_IBF_BIT     = 3;
  localparam int          INT_EXT0_BIT    = 4;
  localparam int          INT_EXT1_BIT    = 5;
  localparam int          INT_TIMER_BIT   = 8;
  localparam logic [15:0] INT_EN_MASK     = 16'h013c;
  localparam logic [15:0] INT_EN_RESET    = 16'h0000;

  // host status byte seen over the pins
  localparam int          HSR_IBF_BIT     = 0;
  localparam int          HSR_OBE_BIT     = 1;

  // idle levels of the synchronised pin groups, loaded during reset
  localparam logic [11:0] DEV_PIN_IDLE    = 12'hff3;
  localparam logic [9:0]  HOST_PIN_IDLE   = 10'h3fe;

  // ==========================================================================
  // host-side register map
  localparam logic [3:0]  ADDR_HOST_CFG   = 4'h0;
  localparam logic [3:0]  ADDR_HOST_CMD   = 4'h1;
  localparam logic [3:0]  ADDR_HOST_STAT  = 4'h2;
  localparam int          CMD_READ_BIT    = 8;
  localparam int          CMD_REGSEL_BIT  = 9;
  localparam int          CMD_BSEL_BIT    = 10;
  localparam int          HST_BUSY_BIT    = 8;
  localparam int          HST_IBF_BIT     = 9;
  localparam int          HST_OBE_BIT     = 10;

  // ==========================================================================
  // host strobe timing
  localparam int          CLK_NS          = 10;
  localparam int          STRB_NS         = 80;
  localparam int          HOLD_NS         = 40;
  localparam logic [3:0]  STRB_CYCLES     = 4'((STRB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  HOLD_CYCLES     = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
endpackage

// ===== hw/hpci_if.sv
/*
  pins of the 8-bit parallel host port between host and device.
  assumes the bench ties both ends to one instance; the shared data bus is resolved here.
*/
interface hpci_if;
  logic       inputDataStrobe;
  logic       outputDataStrobe;
  logic       byteSelectPin;
  logic       regSelPin;
  logic       inputBufferFullPin;
  logic       outputBufferEmptyPin;
  logic [7:0] hostDataOut;
  logic       hostDataOeN;
  logic [7:0] devDataOut;
  logic       devDataOeN;
  logic [7:0] dataBus;

  // ==========================================================================
  // bus resolution: undriven bus floats high
  assign dataBus = !devDataOeN ? devDataOut : (!hostDataOeN ? hostDataOut : 8'hff);

  modport device (
    input  inputDataStrobe, outputDataStrobe, byteSelectPin, regSelPin, dataBus,
    output inputBufferFullPin, outputBufferEmptyPin, devDataOut, devDataOeN
  );
  modport host (
    output inputDataStrobe, outputDataStrobe, byteSelectPin, regSelPin, hostDataOut, hostDataOeN,
    input  inputBufferFullPin, outputBufferEmptyPin, dataBus
  );
endinterface

// ===== hw/hpci_sync.sv
/*
  two-flop synchroniser for a group of pin inputs.
  assumes inputs arrive from outside the clk_sys domain.
*/
module hpci_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;

  // ==========================================================================
  // one two-flop chain per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        // idle pin level, so no strobe looks active just after release
        stage1[i] <= IDLE[i];
        dout[i]   <= IDLE[i];
      end else begin
        stage1[i] <= din[i];
        dout[i]   <= stage1[i];
      end
    end
  end
endmodule // hpci_sync

// ===== hw/hpci_device.sv
/*
  device end of the parallel host port: control, interrupt enable and status registers,
  strobe decode, byte steering and buffer flag pins.
  assumes the host holds strobes and data stable for several clk_sys cycles.
*/
// The implementer's own choices: the register offsets and the plain strobed port.
// How it works
// R01 - width bit: 0 byte, 1 word
// R02 - sense set, 8-bit: select high means low
// R03 - sense set, 16-bit: select low means high
// R04 - protocol 0: separate input, output strobes
// R05 - protocol 1: read/write line plus strobe
// R06 - strobe polarity bit: 0 low, 1 high; code uses it in protocol 1 only, protocol 0 strobes are active low
// R07 - flag pins polarity follows flag polarity bit
// R08 - merge bit ORs both flags onto full pin
// R09 - status polarity bit inverts empty read back
// R10 - enable bit 0 blocks, 1 allows
// R11 - status bit one while interrupt pending
// R12 - writing one clears bits 4, 5, 8
// R13 - reserved bits read zero, ignore writes
module hpci_device
  import hpci_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [15:0] rdata,
  input  wire logic [1:0]  extIrq,
  input  wire logic        timerIrq,
  output logic             irqPending,
  hpci_if.device           link
);
  typedef struct packed {
    logic [CTL_BITS-1:0] ctl;
    logic [15:0]         intEn;
    logic [2:0]          extPend;
    logic [15:0]         inBuf;
    logic                ibf;
    logic [15:0]         outBuf;
    logic                obe;
    logic                prevWr;
    logic                prevRd;
    logic [7:0]          capData;
    logic                capLow;
    logic                capReg;
    logic [15:0]         rdata;
    logic                irq;
    logic                ibfPin;
    logic                obePin;
    logic [7:0]          dataOut;
    logic                dataOeN;
  } hpci_dev_s;

  hpci_dev_s   q;
  hpci_dev_s   next_q;
  logic [11:0] pins;

  hpci_sync #(.W(12), .IDLE(DEV_PIN_IDLE)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({link.dataBus, link.regSelPin, link.byteSelectPin,
                link.outputDataStrobe, link.inputDataStrobe}),
    .dout    (pins)
  );

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic        ids;
    logic        ods;
    logic        bsel;
    logic        regSel;
    logic [7:0]  busData;
    logic        dsAct;
    logic        wrAct;
    logic        rdAct;
    logic        lowSel;
    logic        wide;
    logic        wrDone;
    logic        rdDone;
    logic        obeStat;
    logic        flagIbf;
    logic [15:0] status;
    logic [2:0]  extSet;
    logic [2:0]  extClr;
    ids     = pins[0];
    ods     = pins[1];
    bsel    = pins[2];
    regSel  = pins[3];
    busData = pins[11:4];
    next_q  = q;
    wide    = q.ctl[CTL_WIDTH_SEL]; // R01
    wrAct   = 1'b0;
    rdAct   = 1'b0;

    // access decode
    dsAct = q.ctl[CTL_STRB_POL] ? ods : !ods; // R06
    if (!q.ctl[CTL_PROTO_SEL]) begin
      wrAct = !ids; // R04
      rdAct = !ods; // R04
    end else begin
      wrAct = dsAct && !ids; // R05
      rdAct = dsAct && ids; // R05
    end
    lowSel = q.ctl[CTL_BSEL_SENSE] ? bsel : !bsel; // R01 R02 R03
    if (!wide) begin
      lowSel = 1'b1; // R01
    end

    obeStat = q.ctl[CTL_STAT_POL] ? !q.obe : q.obe; // R09

    // host write: capture while strobe active, commit on release
    next_q.prevWr = wrAct;
    next_q.prevRd = rdAct;
    if (wrAct) begin
      next_q.capData = busData;
      next_q.capLow  = lowSel;
      next_q.capReg  = regSel;
    end
    wrDone = q.prevWr && !wrAct && !q.capReg;
    rdDone = q.prevRd && !rdAct && !regSel;

    // software read of input data clears full; a host commit in the same cycle wins
    if (rdStb && addr == ADDR_IN_DATA) begin
      next_q.ibf = 1'b0;
    end
    if (wrDone) begin
      if (q.capLow) begin
        next_q.inBuf[7:0] = q.capData;
      end else begin
        next_q.inBuf[15:8] = q.capData;
      end
      if (!wide || !q.capLow) begin
        next_q.ibf = 1'b1; // R01
      end
    end

    // software write of output data clears empty; host read of last byte sets empty
    if (wrStb && addr == ADDR_OUT_DATA) begin
      next_q.outBuf = wdata;
      next_q.obe    = 1'b0;
    end
    if (rdDone && (!wide || !lowSel)) begin
      next_q.obe = 1'b1; // R01
    end

    // pin data drive
    next_q.dataOeN = !rdAct;
    if (regSel) begin
      next_q.dataOut = 8'h00;
      next_q.dataOut[HSR_IBF_BIT] = q.ibf;
      next_q.dataOut[HSR_OBE_BIT] = obeStat; // R09
    end else begin
      next_q.dataOut = lowSel ? q.outBuf[7:0] : q.outBuf[15:8]; // R02 R03
    end

    // flag pins
    flagIbf       = q.ctl[CTL_MERGE_SEL] ? (q.ibf || q.obe) : q.ibf; // R08
    next_q.ibfPin = q.ctl[CTL_FLAG_POL] ? !flagIbf : flagIbf; // R07
    next_q.obePin = q.ctl[CTL_FLAG_POL] ? !q.obe : q.obe; // R07 R08

    // interrupts: set wins over a write-one clear
    extSet = {timerIrq && q.intEn[INT_TIMER_BIT],
              extIrq[1] && q.intEn[INT_EXT1_BIT],
              extIrq[0] && q.intEn[INT_EXT0_BIT]}; // R10
    extClr = 3'h0;
    if (wrStb && addr == ADDR_INT_STATUS) begin
      extClr = {wdata[INT_TIMER_BIT], wdata[INT_EXT1_BIT], wdata[INT_EXT0_BIT]}; // R12
    end
    next_q.extPend = (q.extPend & ~extClr) | extSet; // R12

    status = 16'h0000;
    status[INT_IBF_BIT]   = q.ibf && q.intEn[INT_IBF_BIT]; // R10 R11
    status[INT_OBE_BIT]   = q.obe && q.intEn[INT_OBE_BIT]; // R10 R11
    status[INT_EXT0_BIT]  = q.extPend[0]; // R11
    status[INT_EXT1_BIT]  = q.extPend[1]; // R11
    status[INT_TIMER_BIT] = q.extPend[2]; // R11
    next_q.irq = |status;

    // register writes
    if (wrStb && addr == ADDR_CONTROL) begin
      next_q.ctl = wdata[CTL_BITS-1:0]; // R13
    end
    if (wrStb && addr == ADDR_INT_ENABLE) begin
      next_q.intEn = wdata & INT_EN_MASK; // R13
    end

    // register reads, data one cycle later
    next_q.rdata = 16'h0000;
    if (rdStb) begin
      unique case (addr)
        ADDR_CONTROL:    next_q.rdata = {{(16-CTL_BITS){1'b0}}, q.ctl}; // R13
        ADDR_INT_ENABLE: next_q.rdata = q.intEn;
        ADDR_INT_STATUS: next_q.rdata = status;
        ADDR_IN_DATA:    next_q.rdata = q.inBuf;
        ADDR_OUT_DATA:   next_q.rdata = q.outBuf;
        default:         next_q.rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q         <= '0;
      q.ctl     <= CTL_RESET;
      q.intEn   <= INT_EN_RESET;
      q.obe     <= 1'b1;
      q.obePin  <= 1'b1;
      q.dataOeN <= 1'b1;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign rdata                     = q.rdata;
  assign irqPending                = q.irq;
  assign link.inputBufferFullPin   = q.ibfPin;
  assign link.outputBufferEmptyPin = q.obePin;
  assign link.devDataOut           = q.dataOut;
  assign link.devDataOeN           = q.dataOeN;
endmodule // hpci_device

// ===== hw/hpci_host.sv
/*
  host end of the parallel host port: runs single byte accesses on the pins under
  command of its own register port, mirroring the device's protocol settings.
  assumes software sets the same control bits in both ends.
*/
module hpci_host
  import hpci_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [15:0] rdata,
  hpci_if.host             link
);
  typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} hpci_state_e;

  typedef struct packed {
    hpci_state_e         state;
    logic [3:0]          cnt;
    logic [CTL_BITS-1:0] cfg;
    logic                isRead;
    logic [7:0]          lastData;
    logic                ids;
    logic                ods;
    logic                bsel;
    logic                regSel;
    logic [7:0]          dataOut;
    logic                dataOeN;
    logic [15:0]         rdata;
  } hpci_host_s;

  hpci_host_s q;
  hpci_host_s next_q;
  logic [9:0] pins;

  hpci_sync #(.W(10), .IDLE(HOST_PIN_IDLE)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({link.dataBus, link.outputBufferEmptyPin, link.inputBufferFullPin}),
    .dout    (pins)
  );

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic idleOds;
    logic actOds;
    logic flagPol;
    next_q  = q;
    flagPol = q.cfg[CTL_FLAG_POL];
    // inactive and active level of the output strobe pin
    idleOds = q.cfg[CTL_PROTO_SEL] ? !q.cfg[CTL_STRB_POL] : 1'b1; // R06
    actOds  = !idleOds;

    unique case (q.state)
      IDLE: begin
        next_q.ids = 1'b1;
        next_q.ods = idleOds;
        if (wrStb && addr == ADDR_HOST_CMD) begin
          next_q.isRead  = wdata[CMD_READ_BIT];
          next_q.regSel  = wdata[CMD_REGSEL_BIT];
          next_q.bsel    = wdata[CMD_BSEL_BIT]; // R01
          next_q.dataOut = wdata[7:0];
          next_q.dataOeN = wdata[CMD_READ_BIT];
          next_q.ids     = q.cfg[CTL_PROTO_SEL] ? wdata[CMD_READ_BIT] : 1'b1; // R05
          next_q.state   = SETUP;
        end
      end
      SETUP: begin
        if (q.cfg[CTL_PROTO_SEL]) begin
          next_q.ods = actOds; // R05 R06
        end else if (q.isRead) begin
          next_q.ods = 1'b0; // R04
        end else begin
          next_q.ids = 1'b0; // R04
        end
        next_q.cnt   = STRB_CYCLES;
        next_q.state = STROBE;
      end
      STROBE: begin
        next_q.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          if (q.isRead) begin
            next_q.lastData = pins[9:2];
          end
          next_q.ods   = idleOds;
          next_q.ids   = q.cfg[CTL_PROTO_SEL] ? q.ids : 1'b1;
          next_q.cnt   = HOLD_CYCLES;
          next_q.state = HOLD;
        end
      end
      HOLD: begin
        next_q.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          next_q.dataOeN = 1'b1;
          next_q.ids     = 1'b1;
          next_q.state   = IDLE;
        end
      end
    endcase

    if (wrStb && addr == ADDR_HOST_CFG && q.state == IDLE) begin
      next_q.cfg = wdata[CTL_BITS-1:0];
    end

    next_q.rdata = 16'h0000;
    if (rdStb) begin
      unique case (addr)
        ADDR_HOST_CFG:  next_q.rdata = {{(16-CTL_BITS){1'b0}}, q.cfg};
        ADDR_HOST_STAT: begin
          next_q.rdata               = {8'h00, q.lastData};
          next_q.rdata[HST_BUSY_BIT] = q.state != IDLE;
          next_q.rdata[HST_IBF_BIT]  = flagPol ? !pins[0] : pins[0]; // R07
          next_q.rdata[HST_OBE_BIT]  = flagPol ? !pins[1] : pins[1]; // R07
        end
        default:        next_q.rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q         <= '0;
      q.state   <= IDLE;
      q.cfg     <= CTL_RESET;
      q.ids     <= 1'b1;
      q.ods     <= 1'b1;
      q.dataOeN <= 1'b1;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign rdata                 = q.rdata;
  assign link.inputDataStrobe  = q.ids;
  assign link.outputDataStrobe = q.ods;
  assign link.byteSelectPin    = q.bsel;
  assign link.regSelPin        = q.regSel;
  assign link.hostDataOut      = q.dataOut;
  assign link.hostDataOeN      = q.dataOeN;
endmodule // hpci_host

// ===== bench/hpci_assertions.sv
/*
  concurrent checks on the pins joining the two ends of the parallel host port.
  assumes one hpci_if instance, the shared clk_sys and the synchronous rst_n.
*/
module hpci_assertions (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       inputDataStrobe,
  input wire logic       outputDataStrobe,
  input wire logic       byteSelectPin,
  input wire logic       regSelPin,
  input wire logic [7:0] hostDataOut,
  input wire logic       hostDataOeN,
  input wire logic [7:0] devDataOut,
  input wire logic       devDataOeN
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // sequences
  sequence s_dev_window;
    !devDataOeN [*5] ##[1:6] devDataOeN;
  endsequence
  sequence s_in_active;
    !inputDataStrobe [*8];
  endsequence
  sequence s_out_active;
    !outputDataStrobe [*8];
  endsequence

  // ==========================================================================
  // properties
  chk_bus_no_contention: assert property (!(!devDataOeN && !hostDataOeN))
    else $error("both ends drive the data bus");
  chk_dev_drive_span: assert property ($fell(devDataOeN) |-> s_dev_window)
    else $error("device read drive window has the wrong length");
  chk_in_strobe_len: assert property ($fell(inputDataStrobe) |-> s_in_active)
    else $error("input strobe shorter than eight cycles");
  chk_out_strobe_len: assert property ($fell(outputDataStrobe) |-> s_out_active)
    else $error("output strobe shorter than eight cycles");
  chk_host_drive_len: assert property ($fell(hostDataOeN) |-> !hostDataOeN [*8])
    else $error("host write drive too short");
  chk_host_data_hold: assert property (!hostDataOeN && !$past(hostDataOeN) |-> $stable(hostDataOut))
    else $error("host write data changed while driven");
  chk_dev_data_hold: assert property (!devDataOeN && !$past(devDataOeN) |-> $stable(devDataOut))
    else $error("device read data changed while driven");
  chk_select_held: assert property (!devDataOeN |-> $stable(byteSelectPin) && $stable(regSelPin))
    else $error("byte or register select moved during a read");
endmodule // hpci_assertions

// ===== bench/host_port_config_irq_tb.sv
/*
  self-checking bench: host end and device end joined by one hpci_if, both driven
  through their software ports.
  assumes the design files under hw/ and the checker are compiled first.
*/
module host_port_config_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hpci_pkg::*;

  logic        clk_sys = 1'h0;
  logic        rst_n = 1'h0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic        dWr = 1'h0;
  logic        dRd = 1'h0;
  logic        hWr = 1'h0;
  logic        hRd = 1'h0;
  logic [1:0]  extIrq = 2'h0;
  logic        timerIrq = 1'h0;
  logic [15:0] dRdata;
  logic [15:0] hRdata;
  logic        irqPending;
  logic [15:0] q;
  logic [15:0] pv [3] = '{16'h0000, 16'h0002, 16'h0006};
  logic [7:0]  b;
  int          nMismatch = 0;
  int          testsRun = 0;
  int          cycles = 0;

  always #5 clk_sys = ~clk_sys;

  // ==========================================================================
  // design and checker
  hpci_if i_hpci_if ();
  hpci_device i_hpci_device (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'h1), .addr(addr), .wdata(wdata),
    .wrStb(dWr), .rdStb(dRd), .rdata(dRdata), .extIrq(extIrq), .timerIrq(timerIrq),
    .irqPending(irqPending), .link(i_hpci_if));
  hpci_host i_hpci_host (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'h1), .addr(addr), .wdata(wdata),
    .wrStb(hWr), .rdStb(hRd), .rdata(hRdata), .link(i_hpci_if));
  hpci_assertions i_hpci_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
    .inputDataStrobe(i_hpci_if.inputDataStrobe), .outputDataStrobe(i_hpci_if.outputDataStrobe),
    .byteSelectPin(i_hpci_if.byteSelectPin), .regSelPin(i_hpci_if.regSelPin),
    .hostDataOut(i_hpci_if.hostDataOut), .hostDataOeN(i_hpci_if.hostDataOeN),
    .devDataOut(i_hpci_if.devDataOut), .devDataOeN(i_hpci_if.devDataOeN));

  // ==========================================================================
  // tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one software port cycle; read data taken in the cycle after the strobe
  task automatic acc(input logic host, input logic wr, input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    hWr <= host & wr;
    hRd <= host & !wr;
    dWr <= !host & wr;
    dRd <= !host & !wr;
    @(posedge clk_sys);
    {hWr, hRd, dWr, dRd} <= 4'h0;
    #1;
    q = host ? hRdata : dRdata;
    @(posedge clk_sys);
  endtask

  task automatic cfg(input logic [15:0] v);
    acc(1'h0, 1'h1, ADDR_CONTROL, v);
    acc(1'h1, 1'h1, ADDR_HOST_CFG, v);
    // a new idle strobe level must stand as long as a strobe before the next command
    repeat (8) @(posedge clk_sys);
  endtask

  // host pin access, then polls host status until idle; q keeps the status
  task automatic hop(input logic [15:0] cmd);
    acc(1'h1, 1'h1, ADDR_HOST_CMD, cmd);
    for (int i = 0; i < 40; i++) begin
      acc(1'h1, 1'h0, ADDR_HOST_STAT, 16'h0);
      if (q[HST_BUSY_BIT] === 1'h0) break;
    end
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic pins(input logic [1:0] e);
    check("flag pins", {14'h0, i_hpci_if.inputBufferFullPin, i_hpci_if.outputBufferEmptyPin}, {14'h0, e});
  endtask

  task automatic irqs(input logic [2:0] v);
    extIrq <= v[1:0];
    timerIrq <= v[2];
    repeat (3) @(posedge clk_sys);
    extIrq <= 2'h0;
    timerIrq <= 1'h0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic rd(input string name, input logic [3:0] a, input logic [15:0] e);
    acc(1'h0, 1'h0, a, 16'h0);
    check(name, q, e);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      nMismatch++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    rd("control", ADDR_CONTROL, 16'h0000);
    rd("status", ADDR_INT_STATUS, 16'h0000);
    pins(2'h1);
    acc(1'h0, 1'h1, ADDR_CONTROL, 16'hffff);
    // the full word opens a read decode; let it last long enough for the drive-window check
    repeat (2) @(posedge clk_sys);
    rd("control", ADDR_CONTROL, 16'h007f);
    cfg(16'h0000);
    acc(1'h0, 1'h1, ADDR_INT_ENABLE, 16'hffff);
    rd("enable", ADDR_INT_ENABLE, 16'h013c);
    rd("status", ADDR_INT_STATUS, 16'h0004);
    check("irq", {15'h0, irqPending}, 16'h0001);
    acc(1'h0, 1'h1, ADDR_INT_ENABLE, 16'h0000);
    irqs(3'h7);
    rd("status", ADDR_INT_STATUS, 16'h0000);
    acc(1'h0, 1'h1, ADDR_INT_ENABLE, 16'h0130);
    irqs(3'h7);
    rd("status", ADDR_INT_STATUS, 16'h0130);
    acc(1'h0, 1'h1, ADDR_INT_STATUS, 16'h0010);
    rd("status", ADDR_INT_STATUS, 16'h0120);
    acc(1'h0, 1'h1, ADDR_INT_STATUS, 16'h0120);
    rd("status", ADDR_INT_STATUS, 16'h0000);
    check("irq", {15'h0, irqPending}, 16'h0000);
    // byte write and read in each strobe protocol
    for (int i = 0; i < 3; i++) begin
      cfg(pv[i]);
      b = 8'h5a + 8'(i);
      hop({8'h00, b});
      pins(2'h3);
      acc(1'h0, 1'h0, ADDR_IN_DATA, 16'h0);
      check("in data", {8'h0, q[7:0]}, {8'h0, b});
      acc(1'h0, 1'h1, ADDR_OUT_DATA, {8'h00, ~b});
      hop(16'h0100);
      check("out data", {8'h0, q[7:0]}, {8'h0, ~b});
    end
    cfg(16'h0010);
    pins(2'h2);
    cfg(16'h0020);
    pins(2'h3);
    cfg(16'h0000);
    pins(2'h1);
    hop(16'h0300);
    check("host status", {14'h0, q[1:0]}, 16'h0002);
    cfg(16'h0040);
    hop(16'h0300);
    check("host status", {14'h0, q[1:0]}, 16'h0000);
    cfg(16'h0008);
    hop(16'h0499);
    acc(1'h0, 1'h0, ADDR_IN_DATA, 16'h0);
    check("in data", {8'h0, q[7:0]}, 16'h0099);
    // word transfers, both senses of the byte select
    cfg(16'h0001);
    hop(16'h0034);
    hop(16'h0412);
    rd("in word", ADDR_IN_DATA, 16'h1234);
    cfg(16'h0009);
    hop(16'h0478);
    hop(16'h0056);
    rd("in word", ADDR_IN_DATA, 16'h5678);
    acc(1'h0, 1'h1, ADDR_OUT_DATA, 16'habcd);
    hop(16'h0500);
    check("out low", {8'h0, q[7:0]}, 16'h00cd);
    hop(16'h0100);
    check("out high", {8'h0, q[7:0]}, 16'h00ab);
    report_and_stop();
  end
endmodule // host_port_config_irq_tb
